// *** pkg/readback_pkg.sv ***
// Shared constants and types of the sensor command response block.
// Assumes one 50 MHz clock domain; the link pins are sampled by that clock.
package readback_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the 32-bit bus.
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_THR = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam int ADDR_LSB_W = 4;

  // Configuration field positions in the configuration register.
  localparam int CFG_DET_BIT = 0;
  localparam int CFG_ABS_BIT = 1;
  localparam int CFG_ANG_BIT = 2;
  // Field limit code sits in the top three bits of the threshold setting.
  localparam int LIMIT_HI = 15;
  localparam int LIMIT_LO = 13;
  localparam int PUSH_HI = 12;

  // Status byte bit positions.
  localparam int ST_CONT = 7;
  localparam int ST_WAKE = 6;
  localparam int ST_SNGL = 5;
  localparam int ST_FAIL = 4;
  localparam int ST_PUSH = 3;
  localparam int ST_LIMIT = 2;
  localparam int ST_RESTART = 1;
  localparam int ST_FRESH = 0;

  // Upper nibble of a command byte; the lower nibble is the item select.
  localparam logic [3:0] CMD_CONT = 4'h1;
  localparam logic [3:0] CMD_WAKE = 4'h2;
  localparam logic [3:0] CMD_SNGL = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h4;
  localparam logic [3:0] CMD_RREG = 4'h5;
  localparam logic [3:0] CMD_WREG = 4'h6;
  localparam logic [3:0] CMD_IDLE = 4'h8;
  localparam logic [3:0] CMD_RESET = 4'hf;

  // Largest readback payload: four 16-bit items.
  localparam int DATA_BYTES = 8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    MODE_IDLE = 4'b0001,
    MODE_CONT = 4'b0010,
    MODE_WAKE = 4'b0100,
    MODE_SNGL = 4'b1000
  } mode_e;

  typedef enum logic [3:0] {
    PH_CMD = 4'b0001,
    PH_ARM = 4'b0010,
    PH_RESP = 4'b0100,
    PH_SKIP = 4'b1000
  } phase_e;

  typedef struct packed {
    logic ang_sel;
    logic abs_en;
    logic det_sel;
    logic [15:0] thr;
  } cfg_s;

  localparam cfg_s CFG_RST = '{ang_sel: 1'b0, abs_en: 1'b0, det_sel: 1'b0, thr: 16'h0000};

  // Results from the measurement core, raw offset binary for the axes.
  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
    logic [15:0] t;
  } results_s;

endpackage : readback_pkg

// *** logic/sensor_status_readback.sv ***
// Command response logic: serial command decode, status byte and readback.
// Assumes a measurement core on ref_clk and a serial host on sampled pins.
//
// Contract
// (R1) Reset command restores configuration defaults.
// (R2) Host idles device before sending reset.
// (R3) Every non-reset command returns status byte.
// (R4) Continuous bit set in continuous responses.
// (R5) Wake-up bit set in wake-up responses.
// (R6) Single bit set until conversion completes.
// (R7) Measurement command during measurement flags failure.
// (R8) Register command during continuous flags failure.
// (R9) Early continuous readback fails, returns nothing.
// (R10) Plane field above threshold sets push.
// (R11) Field above limit code sets limit flag.
// (R12) Reset sends nothing; next status shows restart.
// (R13) Continuous completion sets fresh; read clears.
// (R14) Single or wake event sets fresh.
// (R15) Readback returns status then data together.
// (R16) Host gates continuous readback on result pin.
// (R17) Field mode gives temperature and axes.
// (R18) Axis words pass as offset binary.
// (R19) Order is status, T, X, Y, Z.
// (R20) Unselected items omitted, order kept.
// (R21) Low nibble selects Z Y X T.
// (R22) Result pin rises on completion, falls on read.
// (R23) Each word goes high byte first.
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps

module sensor_status_readback (
  input wire logic ref_clk, // System clock, 50 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic hsel, // Bus slave select.
  input wire logic [31:0] haddr, // Bus address.
  input wire logic [1:0] htrans, // Bus transfer type.
  input wire logic hwrite, // Bus write flag.
  input wire logic [2:0] hsize, // Bus transfer size.
  input wire logic [31:0] hwdata, // Bus write data.
  input wire logic hready, // Bus ready in.
  output logic hreadyout, // Slave ready out.
  output logic hresp, // Slave response, always okay.
  output logic [31:0] hrdata, // Bus read data.
  input wire logic sclk, // Serial clock from host.
  input wire logic cs_n, // Serial select, active low.
  input wire logic mosi, // Serial data in.
  output logic miso, // Serial data out.
  input wire logic external_pulse_input, // Conversion trigger pin.
  output logic button_output_pin, // Push detected.
  output logic result_flag_pin, // Fresh results waiting.
  input wire logic meas_done, // Core finished a measurement.
  input wire logic wake_hit, // Core saw a field change over threshold.
  input wire readback_pkg::results_s results, // Latest results.
  input wire logic [15:0] plane_field, // Selected plane field magnitude.
  output readback_pkg::mode_e meas_mode, // Mode for the core.
  output logic [3:0] meas_items // Item select for the core.
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] sclk_s;
    logic sclk_q;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic [1:0] trg_s;
    logic trg_q;
    readback_pkg::mode_e mode;
    logic [3:0] items;
    readback_pkg::cfg_s cfg;
    logic restart;
    logic fresh;
    logic push;
    logic limit;
    readback_pkg::phase_e ph;
    logic [7:0] rx;
    logic [2:0] bitc;
    logic [7:0] tx;
    logic [63:0] dbuf;
    logic [3:0] nbytes;
    logic miso;
    logic a_act;
    logic a_wr;
    logic [3:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
  } state_s;

  localparam state_s ST_RST = '{
    sclk_s: 2'b00, sclk_q: 1'b0, cs_s: 2'b11, mosi_s: 2'b00, trg_s: 2'b00,
    trg_q: 1'b0, mode: readback_pkg::MODE_IDLE, items: 4'h0,
    cfg: readback_pkg::CFG_RST, restart: 1'b1, fresh: 1'b0, push: 1'b0,
    limit: 1'b0, ph: readback_pkg::PH_CMD, rx: 8'h00, bitc: 3'h0, tx: 8'h00,
    dbuf: 64'h0, nbytes: 4'h0, miso: 1'b0, a_act: 1'b0, a_wr: 1'b0,
    a_addr: 4'h0, hrdata: 32'h0, hready: 1'b1};

  state_s st;
  state_s nx;
  logic rise;
  logic fall;
  logic sel;
  logic dec;
  logic [7:0] cmd;
  logic ev;
  logic [3:0][15:0] words;
  logic [7:0] live_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Edges are found on the second synchroniser stage against a third copy.
  assign rise = st.sclk_s[1] && !st.sclk_q;
  assign fall = !st.sclk_s[1] && st.sclk_q;
  assign sel = !st.cs_s[1];
  assign dec = sel && rise && (st.ph == readback_pkg::PH_CMD) && (st.bitc == 3'd7);
  assign cmd = {st.rx[6:0], st.mosi_s[1]};
  // Item index 0 is temperature, 3 is Z, matching the select nibble.
  assign words = {results.z, results.y, results.x, results.t}; // [R21]
  assign live_stat = {st.mode == readback_pkg::MODE_CONT, st.mode == readback_pkg::MODE_WAKE,
                      st.mode == readback_pkg::MODE_SNGL, 1'b0, st.push, st.limit,
                      st.restart, st.fresh};
  // Measurement events that produce a fresh result set.
  assign ev = (meas_done && (st.mode == readback_pkg::MODE_CONT ||
               st.mode == readback_pkg::MODE_SNGL)) ||
              (wake_hit && st.mode == readback_pkg::MODE_WAKE);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.
  always_comb begin
    readback_pkg::mode_e nm;
    logic fail;
    logic rd;
    logic [63:0] b;
    logic [3:0] n;
    logic [7:0] nb;
    nm = st.mode;
    fail = 1'b0;
    rd = 1'b0;
    b = 64'h0;
    n = 4'h0;
    nb = 8'h00;
    nx = st;
    nx.sclk_s = {st.sclk_s[0], sclk};
    nx.sclk_q = st.sclk_s[1];
    nx.cs_s = {st.cs_s[0], cs_n};
    nx.mosi_s = {st.mosi_s[0], mosi};
    nx.trg_s = {st.trg_s[0], external_pulse_input};
    nx.trg_q = st.trg_s[1];

    // A finished single conversion drops the device back to idle.
    if (meas_done && st.mode == readback_pkg::MODE_SNGL) begin
      nx.mode = readback_pkg::MODE_IDLE; // [R6]
    end
    // A rising trigger pin starts a single conversion only from idle.
    if (st.trg_s[1] && !st.trg_q && st.mode == readback_pkg::MODE_IDLE) begin
      nx.mode = readback_pkg::MODE_SNGL; // [R6]
    end

    // Detection flags follow the field live each cycle.
    nx.push = st.cfg.det_sel &&
      (plane_field > {3'b000, st.cfg.thr[readback_pkg::PUSH_HI:0]}); // [R10]
    nx.limit = !st.cfg.abs_en && (plane_field >
      {st.cfg.thr[readback_pkg::LIMIT_HI:readback_pkg::LIMIT_LO], 13'h0000}); // [R11]

    // Bus address phase; a read answers from flops in the data phase.
    nx.a_act = hsel && htrans[1] && hready && (hsize == 3'b010);
    nx.a_wr = hwrite;
    nx.a_addr = haddr[readback_pkg::ADDR_LSB_W-1:0];
    nx.hready = 1'b1;
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[readback_pkg::ADDR_LSB_W-1:0])
        readback_pkg::OFS_CFG: nx.hrdata = {29'h0, st.cfg.ang_sel, st.cfg.abs_en, st.cfg.det_sel};
        readback_pkg::OFS_THR: nx.hrdata = {16'h0, st.cfg.thr};
        readback_pkg::OFS_STAT: nx.hrdata = {16'h0, st.mode, st.items, live_stat};
        default: nx.hrdata = 32'h0;
      endcase
    end
    if (st.a_act && st.a_wr) begin
      case (st.a_addr)
        readback_pkg::OFS_CFG: begin
          nx.cfg.det_sel = hwdata[readback_pkg::CFG_DET_BIT];
          nx.cfg.abs_en = hwdata[readback_pkg::CFG_ABS_BIT];
          nx.cfg.ang_sel = hwdata[readback_pkg::CFG_ANG_BIT];
        end
        readback_pkg::OFS_THR: nx.cfg.thr = hwdata[15:0];
        default: nx.cfg = st.cfg;
      endcase
    end

    // Serial frame: command byte in, then status and data out.
    if (!sel) begin
      nx.ph = readback_pkg::PH_CMD;
      nx.bitc = 3'h0;
      nx.miso = 1'b0;
    end else begin
      case (st.ph)
        readback_pkg::PH_CMD: begin
          if (rise) begin
            nx.rx = cmd;
            nx.bitc = st.bitc + 3'd1;
          end
        end
        readback_pkg::PH_ARM: begin
          // First falling edge after the command puts out the status MSB.
          if (fall) begin
            nx.miso = st.tx[7];
            nx.tx = {st.tx[6:0], 1'b0};
            nx.bitc = 3'h0;
            nx.ph = readback_pkg::PH_RESP;
          end
        end
        readback_pkg::PH_RESP: begin
          if (fall && st.bitc == 3'd7) begin
            if (st.nbytes != 4'h0) begin
              nb = st.dbuf[63:56]; // [R23]
              nx.dbuf = {st.dbuf[55:0], 8'h00};
              nx.nbytes = st.nbytes - 4'd1;
            end
            nx.miso = nb[7];
            nx.tx = {nb[6:0], 1'b0};
            nx.bitc = 3'h0;
          end else if (fall) begin
            nx.miso = st.tx[7];
            nx.tx = {st.tx[6:0], 1'b0};
            nx.bitc = st.bitc + 3'd1;
          end
        end
        readback_pkg::PH_SKIP: nx.ph = readback_pkg::PH_SKIP;
        default: nx.ph = readback_pkg::PH_CMD;
      endcase
    end

    // Command decode at the eighth rising edge of the frame.
    if (dec) begin
      if (cmd[7:4] == readback_pkg::CMD_RESET) begin
        // No status follows a reset; the rest of the frame is ignored.
        nx.cfg = readback_pkg::CFG_RST; // [R1]
        nx.mode = readback_pkg::MODE_IDLE;
        nx.restart = 1'b1; // [R12]
        nx.ph = readback_pkg::PH_SKIP; // [R12]
      end else begin
        case (cmd[7:4])
          readback_pkg::CMD_CONT, readback_pkg::CMD_WAKE, readback_pkg::CMD_SNGL: begin
            if (st.mode != readback_pkg::MODE_IDLE) begin
              fail = 1'b1; // [R7]
            end else begin
              nx.items = cmd[3:0]; // [R21]
              case (cmd[7:4])
                readback_pkg::CMD_CONT: nm = readback_pkg::MODE_CONT;
                readback_pkg::CMD_WAKE: nm = readback_pkg::MODE_WAKE;
                default: nm = readback_pkg::MODE_SNGL;
              endcase
            end
          end
          readback_pkg::CMD_IDLE: nm = readback_pkg::MODE_IDLE;
          readback_pkg::CMD_READ: begin
            // Reading before the result pin rises in continuous mode fails.
            fail = (st.mode == readback_pkg::MODE_CONT) && !st.fresh; // [R9] [R16]
            rd = !fail;
          end
          readback_pkg::CMD_RREG, readback_pkg::CMD_WREG: begin
            fail = (st.mode == readback_pkg::MODE_CONT); // [R8]
          end
          default: fail = 1'b1;
        endcase
        nx.mode = nm;
        nx.tx = {nm == readback_pkg::MODE_CONT, nm == readback_pkg::MODE_WAKE,
                 nm == readback_pkg::MODE_SNGL, fail, st.push, st.limit,
                 st.restart, st.fresh}; // [R3] [R4] [R5] [R6]
        nx.restart = 1'b0; // [R12]
        nx.ph = readback_pkg::PH_ARM; // [R3]
        nx.dbuf = 64'h0;
        nx.nbytes = 4'h0;
        if (rd) begin
          // Prepend from Z down to T, so T ends on top and gaps close up.
          for (int i = 3; i >= 0; i--) begin
            if (st.items[i] && !st.cfg.ang_sel) begin // [R17] [R20]
              b = {words[i], b[63:16]}; // [R18] [R19]
              n = n + 4'd2;
            end
          end
          nx.dbuf = b; // [R15]
          nx.nbytes = n;
          nx.fresh = 1'b0; // [R13] [R22]
        end
      end
    end
    // Setting wins over the read clear in the same cycle.
    if (ev) begin
      nx.fresh = 1'b1; // [R13] [R14] [R22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The whole state lives in one register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  assign hreadyout = st.hready;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign miso = st.miso;
  assign button_output_pin = st.push; // [R10]
  assign result_flag_pin = st.fresh; // [R22]
  assign meas_mode = st.mode;
  assign meas_items = st.items;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_decode(logic [3:0] op);
    dec && cmd[7:4] == op;
  endsequence

  sequence s_status_out;
    (st.ph == readback_pkg::PH_ARM) ##1 (st.ph == readback_pkg::PH_RESP);
  endsequence

  AST_RESET_CFG: assert property ( // [R1]
    s_decode(readback_pkg::CMD_RESET) |=> st.cfg == readback_pkg::CFG_RST && st.restart)
    else $error("reset command left configuration changed");

  AST_RESET_SILENT: assert property ( // [R12]
    s_decode(readback_pkg::CMD_RESET) |=> (st.ph == readback_pkg::PH_SKIP && !st.miso)
      throughout (sel [*8]))
    else $error("status sent after reset command");

  AST_STATUS_ANY: assert property ( // [R3]
    dec && cmd[7:4] != readback_pkg::CMD_RESET |=> st.ph == readback_pkg::PH_ARM && !st.restart)
    else $error("no status armed after command");

  AST_CONT_BIT: assert property ( // [R4]
    s_decode(readback_pkg::CMD_CONT) ##0 (st.mode == readback_pkg::MODE_IDLE)
      |=> st.tx[readback_pkg::ST_CONT] && !st.tx[readback_pkg::ST_FAIL])
    else $error("continuous bit missing");

  AST_WAKE_BIT: assert property ( // [R5]
    s_decode(readback_pkg::CMD_WAKE) ##0 (st.mode == readback_pkg::MODE_IDLE)
      |=> st.tx[readback_pkg::ST_WAKE] && st.mode == readback_pkg::MODE_WAKE)
    else $error("wake-up bit missing");

  AST_SINGLE_END: assert property ( // [R6]
    meas_done && st.mode == readback_pkg::MODE_SNGL && !dec
      |=> st.mode == readback_pkg::MODE_IDLE && st.fresh)
    else $error("single conversion did not end in idle");

  AST_MEAS_BUSY: assert property ( // [R7]
    dec && st.mode != readback_pkg::MODE_IDLE && (cmd[7:4] == readback_pkg::CMD_SNGL ||
      cmd[7:4] == readback_pkg::CMD_CONT) |=> st.tx[readback_pkg::ST_FAIL] && $stable(st.mode))
    else $error("measurement command during measurement not refused");

  AST_REG_IN_CONT: assert property ( // [R8]
    dec && st.mode == readback_pkg::MODE_CONT && (cmd[7:4] == readback_pkg::CMD_RREG ||
      cmd[7:4] == readback_pkg::CMD_WREG) |=> st.tx[readback_pkg::ST_FAIL])
    else $error("register command in continuous mode not refused");

  AST_EARLY_READ: assert property ( // [R9]
    s_decode(readback_pkg::CMD_READ) ##0 (st.mode == readback_pkg::MODE_CONT && !st.fresh)
      |=> st.tx[readback_pkg::ST_FAIL] && st.nbytes == 4'h0)
    else $error("early continuous readback returned data");

  AST_PUSH: assert property ( // [R10]
    st.cfg.det_sel && $stable(st.cfg) && plane_field > {3'b000, st.cfg.thr[12:0]}
      |=> button_output_pin && st.push)
    else $error("push detect missed");

  AST_LIMIT: assert property ( // [R11]
    !st.cfg.abs_en && $stable(st.cfg) && plane_field[15:13] > st.cfg.thr[15:13] |=> st.limit)
    else $error("field limit missed");

  AST_FRESH_SET: assert property ( // [R13]
    meas_done && st.mode == readback_pkg::MODE_CONT |=> result_flag_pin)
    else $error("fresh result not flagged");

  AST_FRESH_CLEAR: assert property ( // [R13]
    s_decode(readback_pkg::CMD_READ) ##0 (st.fresh && !ev) |=> !result_flag_pin)
    else $error("fresh result not cleared by read");

  AST_FULL_READ: assert property ( // [R19]
    s_decode(readback_pkg::CMD_READ) ##0 (st.fresh && st.items == 4'hf && !st.cfg.ang_sel)
      |=> st.nbytes == 4'd8 && st.dbuf[63:48] == $past(results.t)
        && st.dbuf[15:0] == $past(results.z))
    else $error("full readback order wrong");

  AST_STATUS_MSB: assert property ( // [R15]
    s_status_out |-> st.miso == $past(st.tx[7]))
    else $error("status did not lead the response");

endmodule : sensor_status_readback

// *** test/spi_host_model.sv ***
// Serial host model: mode 0 frames of one command byte and nine reply bytes.
// Assumes the device samples mosi on sclk rise and shifts miso after each fall.
`timescale 1ns/100ps

module spi_host_model (
  input wire logic ref_clk, // Bench clock; a link half period is four cycles.
  output logic sclk, // Link clock, held low outside frames.
  output logic cs_n, // Frame select, active low.
  output logic mosi, // Command bits to the device.
  input wire logic miso // Reply bits from the device.
);
  // Idle levels at time zero.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Between frames mosi toggles, so the device cannot lean on a stale level.
  always @(posedge ref_clk) begin
    if (cs_n) mosi <= ~mosi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame: command MSB first, then 72 reply bits with mosi toggling.
  // Miso is taken half a cycle before each rise, half a cycle after the device shifted it.
  task automatic frame(input logic [7:0] cmd, output logic [71:0] rx);
    rx = '0;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 80; i++) begin
      mosi <= (i < 8) ? cmd[7 - i] : ~mosi;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      if (i >= 8) rx = {rx[70:0], miso};
      @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : frame
endmodule : spi_host_model

// *** test/testbench.sv ***
// Self-checking bench of the command response block with a serial host model.
// Assumes zero-wait bus answers and a 160 ns link clock made by the host model.
`timescale 1ns/100ps

module testbench;
  localparam int LIMIT = 40000;
  localparam logic [7:0] S_CONT = 8'h01 << readback_pkg::ST_CONT;
  localparam logic [7:0] S_WAKE = 8'h01 << readback_pkg::ST_WAKE;
  localparam logic [7:0] S_SNGL = 8'h01 << readback_pkg::ST_SNGL;
  localparam logic [7:0] S_FAIL = 8'h01 << readback_pkg::ST_FAIL;
  localparam logic [7:0] S_PUSH = 8'h01 << readback_pkg::ST_PUSH;
  localparam logic [7:0] S_LIM = 8'h01 << readback_pkg::ST_LIMIT;
  localparam logic [7:0] S_RST = 8'h01 << readback_pkg::ST_RESTART;
  localparam logic [7:0] S_FRESH = 8'h01 << readback_pkg::ST_FRESH;
  localparam readback_pkg::results_s RES = '{z: 16'h8abc, y: 16'h5678, x: 16'h9532, t: 16'h1234};

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic pulse_in = 1'b0;
  logic meas_done = 1'b0;
  logic wake_hit = 1'b0;
  logic [15:0] plane_field = 16'h0;
  logic hreadyout, hresp, miso, sclk, cs_n, mosi, button_output_pin, result_flag_pin;
  logic [31:0] hrdata, rd;
  readback_pkg::mode_e meas_mode;
  logic [3:0] meas_items;
  logic [71:0] rx;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  // Clock of 20 ns period.
  always #10 ref_clk = ~ref_clk;

  sensor_status_readback u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .external_pulse_input(pulse_in),
    .button_output_pin(button_output_pin), .result_flag_pin(result_flag_pin),
    .meas_done(meas_done), .wake_hit(wake_hit), .results(RES), .plane_field(plane_field),
    .meas_mode(meas_mode), .meas_items(meas_items)
  );

  spi_host_model u_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  ////////////////////////////////////////////////////////////////////////////
  // Ends the run with the counts and the verdict.
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // A hang is cut short here and counted as a mismatch.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      complete_run();
    end
  end

  // Compares one result, wide enough for a whole readback frame.
  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // One single bus transfer; the wait ends only on hready or the bench timeout.
  task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Sends a command and judges only the status byte that comes back.
  task automatic cmd(input logic [7:0] c, input logic [7:0] st);
    u_host.frame(c, rx);
    chk("status byte", {64'h0, st}, {64'h0, rx[71:64]});
  endtask : cmd

  // Sends a readback command and judges the whole reply, trailing zeros too.
  task automatic rdback(input logic [7:0] st, input logic [63:0] data);
    u_host.frame(8'h40, rx);
    chk("readback frame", {st, data}, rx);
  endtask : rdback

  // One-cycle pulse from the measurement core.
  task automatic core_pulse(input logic wake);
    if (wake) wake_hit <= 1'b1;
    else meas_done <= 1'b1;
    @(posedge ref_clk);
    wake_hit <= 1'b0;
    meas_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : core_pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    ahb(1'b0, readback_pkg::OFS_CFG, 32'h0);
    chk("cfg reset", 72'h0, {40'h0, rd});
    chk("hresp", 72'h0, {71'h0, hresp});
    ahb(1'b0, readback_pkg::OFS_STAT, 32'h0);
    chk("status reg", {56'h0, 8'h10, S_RST}, {40'h0, rd});
    ahb(1'b1, 4'hc, 32'hffffffff);
    ahb(1'b0, 4'hc, 32'h0);
    chk("unmapped", 72'h0, {40'h0, rd});
    $display("test regs done");
  endtask : t_regs

  task automatic t_single;
    cmd(8'h80, S_RST);
    cmd(8'h80, 8'h00);
    cmd(8'h3f, S_SNGL);
    chk("core select", {68'hf, readback_pkg::MODE_SNGL}, {64'h0, meas_items, meas_mode});
    cmd(8'h1f, S_SNGL | S_FAIL);
    core_pulse(1'b0);
    rdback(S_FRESH, {RES.t, RES.x, RES.y, RES.z});
    chk("x signed", 72'd5426, {56'h0, rx[47:32] - 16'h8000});
    cmd(8'h40, 8'h00);
    cmd(8'h60, 8'h00);
    cmd(8'h35, S_SNGL);
    core_pulse(1'b0);
    rdback(S_FRESH, {RES.t, RES.y, 32'h0});
    $display("test single done");
  endtask : t_single

  task automatic t_cont;
    cmd(8'h19, S_CONT);
    rdback(S_CONT | S_FAIL, 64'h0);
    cmd(8'h50, S_CONT | S_FAIL);
    core_pulse(1'b0);
    chk("result pin high", 72'h1, {71'h0, result_flag_pin});
    rdback(S_CONT | S_FRESH, {RES.t, RES.z, 32'h0});
    chk("result pin low", 72'h0, {71'h0, result_flag_pin});
    cmd(8'h80, 8'h00);
    cmd(8'h28, S_WAKE);
    core_pulse(1'b1);
    rdback(S_WAKE | S_FRESH, {RES.z, 48'h0});
    cmd(8'h80, 8'h00);
    pulse_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pulse_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cmd(8'h50, S_SNGL);
    $display("test modes done");
  endtask : t_cont

  task automatic t_detect;
    ahb(1'b1, readback_pkg::OFS_CFG, 32'h7);
    ahb(1'b0, readback_pkg::OFS_CFG, 32'h0);
    chk("cfg rw", 72'h7, {40'h0, rd});
    ahb(1'b1, readback_pkg::OFS_THR, 32'hffff2010);
    ahb(1'b0, readback_pkg::OFS_THR, 32'h0);
    chk("thr rw", 72'h2010, {40'h0, rd});
    ahb(1'b1, readback_pkg::OFS_CFG, 32'h1);
    plane_field <= 16'h0011;
    repeat (4) @(posedge ref_clk);
    chk("button pin", 72'h1, {71'h0, button_output_pin});
    cmd(8'h80, S_PUSH | S_FRESH);
    plane_field <= 16'h4000;
    cmd(8'h80, S_PUSH | S_LIM | S_FRESH);
    plane_field <= 16'h2000;
    cmd(8'h80, S_PUSH | S_FRESH);
    plane_field <= 16'h0000;
    repeat (4) @(posedge ref_clk);
    chk("button pin off", 72'h0, {71'h0, button_output_pin});
    $display("test detect done");
  endtask : t_detect

  task automatic t_reset;
    u_host.frame(8'hf0, rx);
    chk("reset reply", 72'h0, rx);
    ahb(1'b0, readback_pkg::OFS_CFG, 32'h0);
    chk("cfg after reset", 72'h0, {40'h0, rd});
    ahb(1'b0, readback_pkg::OFS_THR, 32'h0);
    chk("thr after reset", 72'h0, {40'h0, rd});
    cmd(8'h80, S_RST | S_FRESH);
    cmd(8'h40, S_FRESH);
    $display("test reset done");
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////
  // Reset for 20 cycles, then the scenarios in order; idle before reset command.
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_single();
    t_cont();
    core_pulse(1'b0);
    t_detect();
    t_reset();
    complete_run();
  end
endmodule : testbench
